//--- rtl/adc_control.sv
// ADC control: registers, sample/convert sequencer, scan, result buffer
`timescale 1ns/1ns
module adc_control
  import adc_ctrl_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic [15:0]        rdata,
  input  wire logic          trig_in,
  input  wire logic          cpu_sleep,
  input  wire logic          sar_bit,
  output logic               sample_hold,
  output logic               sar_strobe,
  output logic [11:0]        sar_dac,
  output analog_sel_t        asel,
  output logic               conv_done,
  output logic               irq,
  output logic [10:0]        dma_ia
);
  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONVERT, S_STORE} state_t;

  logic [15:0] con1_q, con1_d, con2_q, con2_d, con3_q, con3_d;
  logic [15:0] con5_q, con5_d, chs_q, chs_d, cssh_q, cssh_d;
  logic [15:0] cssl_q, cssl_d, thr_q, thr_d;
  logic [15:0] rdata_d;
  logic [15:0] buf_q [NUM_CH];
  state_t      st_q, st_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [11:0] sar_q, sar_d;
  logic [3:0]  bitn_q, bitn_d;
  logic [CHW-1:0] ch_q, ch_d;
  logic [3:0]  nconv_q, nconv_d;
  logic        irq_q, irq_d, done_q, done_d, hit_q, hit_d;
  logic [15:0] fmt;
  logic        tick, on;
  logic        trig_s1, trig_s2, trig_s3, trig_ev, trig_lvl_q;
  logic [31:0] scan_mask;
  logic [CHW-1:0] next_ch;
  logic        start;
  logic        store;
  logic [11:0] result;

  assign on = con1_q[BIT_ON];

  tad_divider #(.W(8)) u_div (
    .clk   (clk),
    .reset (reset),
    .run   (on && st_q != S_IDLE),
    .div   (con3_q[ADCS_HI:ADCS_LO]),
    .tick  (tick)
  );

  // Trigger pin: three stages, an edge counts when stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      trig_lvl_q <= 1'b0;
    end else begin
      trig_s1 <= trig_in;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      if (trig_s2 == trig_s3) trig_lvl_q <= trig_s3;
    end
  end
  // A level counts only once stages two and three agree; edge on that level
  assign trig_ev = (trig_s2 == trig_s3) && trig_s3 && !trig_lvl_q;

  // Start source selection
  always_comb begin
    case (con1_q[SSRC_HI:SSRC_LO])
      SRC_MANUAL: start = 1'b0;
      SRC_TRIG:   start = trig_ev;
      SRC_AUTO:   start = 1'b1;
      default:    start = 1'b0;
    endcase
  end

  // Next scanned channel: lowest flagged channel above the current one
  assign scan_mask = {cssh_q, cssl_q};
  always_comb begin
    next_ch = ch_q;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (scan_mask[i] && i > int'(ch_q))
        next_ch = CHW'(i);
    end
    if (next_ch == ch_q) begin
      for (int i = NUM_CH - 1; i >= 0; i--) begin
        if (scan_mask[i])
          next_ch = CHW'(i);
      end
    end
  end

  assign result = con1_q[BIT_MODE12] ? sar_q : {2'b00, sar_q[11:2]};

  // Alignment: integer, signed integer, fractional, signed fractional
  always_comb begin
    case (con1_q[FORM_HI:FORM_LO])
      2'h0: fmt = {4'h0, result};
      2'h1: fmt = {{4{result[11]}}, result};
      2'h2: fmt = {result, 4'h0};
      default: fmt = {~result[11], result[10:0], 4'h0};
    endcase
  end

  // Register writes; sample bit is also cleared by hardware at conversion
  always_comb begin
    con1_d = con1_q;
    con2_d = con2_q;
    con3_d = con3_q;
    con5_d = con5_q;
    chs_d  = chs_q;
    cssh_d = cssh_q;
    cssl_d = cssl_q;
    thr_d  = thr_q;
    if (wr) begin
      case (addr)
        OFF_CON1: con1_d = wdata;
        OFF_CON2: con2_d = wdata;
        OFF_CON3: con3_d = wdata;
        OFF_CON5: con5_d = wdata;
        OFF_CHS:  chs_d  = wdata;
        OFF_CSSH: cssh_d = wdata;
        OFF_CSSL: cssl_d = wdata;
        OFF_THR:  thr_d  = wdata;
        default:  ;
      endcase
    end
    if (st_q == S_SAMPLE && st_d == S_CONVERT)
      con1_d[BIT_SAMPLE_START_BIT] = 1'b0;
    if (st_q == S_STORE)
      con1_d[BIT_DONE] = 1'b1;
    if (!con1_q[BIT_ON])
      con1_d[BIT_DONE] = con1_d[BIT_DONE] & ~wr;
  end

  // Sequencer
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sar_d   = sar_q;
    bitn_d  = bitn_q;
    ch_d    = ch_q;
    nconv_d = nconv_q;
    irq_d   = 1'b0;
    done_d  = 1'b0;
    hit_d   = hit_q;
    store   = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (on && (con1_q[BIT_SAMPLE_START_BIT] || start)) begin
          st_d  = S_SAMPLE;
          cnt_d = '0;
          // At start with scanning on, an unflagged current channel is replaced by next_ch
          if (con2_q[BIT_CSCNA] && !scan_mask[ch_q]) ch_d = next_ch;
        end
      end
      S_SAMPLE: begin
        // Manual mode ends sampling when software drops the sample bit or the sample count reaches SAMC
        if (tick) cnt_d = cnt_q + 5'h01;
        if ((con1_q[SSRC_HI:SSRC_LO] == SRC_MANUAL)
            ? (!con1_q[BIT_SAMPLE_START_BIT] || cnt_q >= con3_q[SAMC_HI:SAMC_LO])
            : (cnt_q >= con3_q[SAMC_HI:SAMC_LO])) begin
          st_d   = S_CONVERT;
          sar_d  = 12'h800;
          bitn_d = 4'hb;
        end
      end
      S_CONVERT: begin
        if (tick) begin
          if (!sar_bit) sar_d[bitn_q] = 1'b0;
          if (bitn_q == 4'h0) begin
            st_d = S_STORE;
          end else begin
            bitn_d = bitn_q - 4'h1;
            sar_d[bitn_q - 4'h1] = 1'b1;
          end
        end
      end
      S_STORE: begin
        store  = 1'b1;
        done_d = 1'b1;
        if (thr_q[BIT_THR_EN])
          hit_d = thr_q[BIT_THR_GT] ? (sar_q > thr_q[11:0])
                                    : (sar_q < thr_q[11:0]);
        if (con2_q[BIT_CSCNA - 8 + 8]) ch_d = next_ch;
        if (nconv_q >= con2_q[SMPI_HI:SMPI_LO]) begin
          nconv_d = '0;
          irq_d   = !thr_q[BIT_THR_EN] || hit_d;
        end else begin
          nconv_d = nconv_q + 4'h1;
        end
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    if (!on) st_d = S_IDLE;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (addr)
      OFF_CON1: rdata_d = con1_q;
      OFF_CON2: rdata_d = con2_q;
      OFF_CON3: rdata_d = con3_q;
      OFF_CON5: rdata_d = con5_q;
      OFF_CHS:  rdata_d = chs_q;
      OFF_CSSH: rdata_d = cssh_q;
      OFF_CSSL: rdata_d = cssl_q;
      OFF_RES:  rdata_d = buf_q[ch_q];
      OFF_STAT: rdata_d = {13'h0000, hit_q, st_q};
      OFF_THR:  rdata_d = thr_q;
      OFF_IA:   rdata_d = {5'h00, dma_ia};
      default:  rdata_d = ZERO_RST;
    endcase
    if (!rd) rdata_d = ZERO_RST;
  end

  // Sleep input deliberately not gating the sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      con1_q  <= CON1_RST;
      con2_q  <= ZERO_RST;
      con3_q  <= ZERO_RST;
      con5_q  <= ZERO_RST;
      chs_q   <= ZERO_RST;
      cssh_q  <= ZERO_RST;
      cssl_q  <= ZERO_RST;
      thr_q   <= ZERO_RST;
      st_q    <= S_IDLE;
      cnt_q   <= '0;
      sar_q   <= '0;
      bitn_q  <= '0;
      ch_q    <= '0;
      nconv_q <= '0;
      irq_q   <= 1'b0;
      done_q  <= 1'b0;
      hit_q   <= 1'b0;
      rdata   <= ZERO_RST;
      for (int i = 0; i < NUM_CH; i++) buf_q[i] <= ZERO_RST;
    end else begin
      con1_q  <= con1_d;
      con2_q  <= con2_d;
      con3_q  <= con3_d;
      con5_q  <= con5_d;
      chs_q   <= chs_d;
      cssh_q  <= cssh_d;
      cssl_q  <= cssl_d;
      thr_q   <= thr_d;
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sar_q   <= sar_d;
      bitn_q  <= bitn_d;
      ch_q    <= ch_d;
      nconv_q <= nconv_d;
      irq_q   <= irq_d;
      done_q  <= done_d;
      hit_q   <= hit_d;
      rdata   <= rdata_d;
      if (store && int'(ch_q) < NUM_CH) buf_q[ch_q] <= fmt;
    end
  end

  // Outputs, all registered
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_hold <= 1'b0;
      sar_strobe  <= 1'b0;
      sar_dac     <= '0;
      asel        <= '0;
      dma_ia      <= '0;
    end else begin
      sample_hold <= (st_d == S_SAMPLE);
      sar_strobe  <= tick && st_q == S_CONVERT;
      sar_dac     <= sar_d;
      asel.ref_sel <= con2_q[REF_HI:REF_LO];
      asel.mux_sel <= chs_q;
      asel.channel <= ch_d;
      dma_ia      <= {5'h00, ch_d, 1'b0};
    end
  end

  assign conv_done = done_q;
  assign irq       = irq_q;
  logic unused_sleep;
  assign unused_sleep = cpu_sleep ^ con5_q[0];
endmodule

//--- rtl/adc_ctrl_pkg.sv
// Package: register map, field positions, reset values and types for the ADC
package adc_ctrl_pkg;
  localparam int AW = 4;
  localparam logic [3:0] OFF_CON1  = 4'h0;
  localparam logic [3:0] OFF_CON2  = 4'h1;
  localparam logic [3:0] OFF_CON3  = 4'h2;
  localparam logic [3:0] OFF_CON5  = 4'h3;
  localparam logic [3:0] OFF_CHS   = 4'h4;
  localparam logic [3:0] OFF_CSSH  = 4'h5;
  localparam logic [3:0] OFF_CSSL  = 4'h6;
  localparam logic [3:0] OFF_RES   = 4'h7;
  localparam logic [3:0] OFF_STAT  = 4'h8;
  localparam logic [3:0] OFF_THR   = 4'h9;
  localparam logic [3:0] OFF_IA    = 4'ha;
  localparam int BIT_ON    = 15;
  localparam int BIT_SAMPLE_START_BIT  = 1;
  localparam int BIT_DONE  = 0;
  localparam int BIT_ASAM  = 2;
  localparam int BIT_MODE12 = 10;
  localparam int REF_HI = 15;
  localparam int REF_LO = 13;
  localparam int SMPI_HI = 5;
  localparam int SMPI_LO = 2;
  localparam int SSRC_HI = 7;
  localparam int SSRC_LO = 4;
  localparam int FORM_HI = 9;
  localparam int FORM_LO = 8;
  localparam int SAMC_HI = 12;
  localparam int SAMC_LO = 8;
  localparam int ADCS_HI = 7;
  localparam int ADCS_LO = 0;
  localparam int BIT_CSCNA = 10;
  localparam int BIT_THR_EN = 15;
  localparam int BIT_THR_GT = 14;
  localparam int NUM_CH = 19;
  localparam int CHW = 5;
  localparam logic [15:0] CON1_RST = 16'h0400;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [3:0] SRC_MANUAL = 4'h0;
  localparam logic [3:0] SRC_TRIG   = 4'h1;
  localparam logic [3:0] SRC_AUTO   = 4'h7;
  localparam int CONV_TAD = 14;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [15:0]   wdata;
    logic          wr;
    logic          rd;
  } bus_req_t;

  typedef struct packed {
    logic [2:0]     ref_sel;
    logic [15:0]    mux_sel;
    logic [CHW-1:0] channel;
  } analog_sel_t;
endpackage

//--- rtl/tad_divider.sv
// Conversion clock tick generator: one pulse every (div+1) system clocks
`timescale 1ns/1ns
module tad_divider
  import adc_ctrl_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         run,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  logic [W-1:0] cnt_q, cnt_d;
  logic         tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q >= div) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule

//--- testbench/adc_control_checker.sv
// Checker: port-level assertions for the ADC control block
`timescale 1ns/1ns
module adc_control_checker
  import adc_ctrl_pkg::*;
(
  input wire logic          clk,
  input wire logic          reset,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0]   wdata,
  input wire logic          wr,
  input wire logic          rd,
  input wire logic [15:0]   rdata,
  input wire logic          trig_in,
  input wire logic          cpu_sleep,
  input wire logic          sar_bit,
  input wire logic          sample_hold,
  input wire logic          sar_strobe,
  input wire logic [11:0]   sar_dac,
  input wire analog_sel_t   asel,
  input wire logic          conv_done,
  input wire logic          irq,
  input wire logic [10:0]   dma_ia
);
  logic [2:0]  ref_q;
  logic [15:0] chs_q;
  logic        on_q;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Shadows of the written fields, so checks do not read the design
  always_ff @(posedge clk) begin
    if (reset) begin
      ref_q <= 3'h0;
      chs_q <= 16'h0000;
      on_q  <= 1'b0;
    end else if (wr) begin
      if (addr == OFF_CON2) ref_q <= wdata[REF_HI:REF_LO];
      if (addr == OFF_CHS) chs_q <= wdata;
      if (addr == OFF_CON1) on_q <= wdata[BIT_ON];
    end
  end
  sequence s_w2;
    wr && addr == OFF_CON2 ##1 !(wr && addr == OFF_CON2) ##1 1'b1;
  endsequence
  sequence s_w4;
    wr && addr == OFF_CHS ##1 !(wr && addr == OFF_CHS) ##1 1'b1;
  endsequence
  sequence s_start;
    wr && addr == OFF_CON1 && wdata[BIT_ON] && wdata[BIT_SAMPLE_START_BIT] &&
      wdata[SSRC_HI:SSRC_LO] == SRC_MANUAL && !sample_hold && !sar_strobe;
  endsequence
  property p_on;
    sample_hold || sar_strobe |-> on_q || $past(on_q);
  endproperty
  property p_manual;
    s_start |-> ##[1:2] sample_hold;
  endproperty
  property p_ref;
    s_w2 |-> asel.ref_sel == ref_q;
  endproperty
  property p_mux;
    s_w4 |-> asel.mux_sel == chs_q;
  endproperty
  property p_excl;
    !(sample_hold && sar_strobe);
  endproperty
  property p_done;
    conv_done |-> !sample_hold ##1 !conv_done;
  endproperty
  property p_irq;
    irq |-> conv_done || $past(conv_done) || $past(conv_done, 2);
  endproperty
  property p_chan;
    asel.channel < NUM_CH;
  endproperty
  property p_ia;
    dma_ia[10:6] == 5'h00 && !dma_ia[0] && dma_ia[5:1] < NUM_CH;
  endproperty
  a_on: assert property (p_on) else $error("run while off");
  a_manual: assert property (p_manual) else $error("no sampling");
  a_ref: assert property (p_ref) else $error("bad ref_sel");
  a_mux: assert property (p_mux) else $error("bad mux_sel");
  a_excl: assert property (p_excl) else $error("overlap");
  a_done: assert property (p_done) else $error("bad done");
  a_irq: assert property (p_irq) else $error("stray irq");
  a_chan: assert property (p_chan) else $error("bad channel");
  a_ia: assert property (p_ia) else $error("bad address");
endmodule
bind adc_control adc_control_checker adc_control_checker_inst (.clk, .reset,
  .addr, .wdata, .wr, .rd, .rdata, .trig_in, .cpu_sleep, .sar_bit,
  .sample_hold, .sar_strobe, .sar_dac, .asel, .conv_done, .irq, .dma_ia);

//--- testbench/sar_model.sv
// Analog front end model: sample-and-hold plus comparator
`timescale 1ns/1ns
module sar_model (
  input  wire logic        clk,
  input  wire logic        sample_hold,
  input  wire logic [11:0] vin,
  input  wire logic [11:0] sar_dac,
  output logic             sar_bit
);
  logic [11:0] held_q;
  // Input is tracked only while sampling; later changes are lost
  always_ff @(posedge clk) begin
    if (sample_hold) begin
      held_q <= vin;
    end
  end
  assign sar_bit = held_q >= sar_dac;
endmodule

//--- testbench/tb_sar_adc_control_setup.sv
// Self-checking bench for the ADC control block
`timescale 1ns/1ns
module tb_sar_adc_control_setup
  import adc_ctrl_pkg::*;
();
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  logic          trig_in = 1'b0;
  logic          cpu_sleep = 1'b1;
  logic [AW-1:0] addr = 4'h0;
  logic [15:0]   wdata = 16'h0000;
  logic [15:0]   rdata;
  logic [15:0]   v;
  logic [11:0]   vin = 12'h000;
  logic [11:0]   sar_dac;
  logic          sar_bit;
  logic          sample_hold;
  logic          sar_strobe;
  logic          conv_done;
  logic          irq;
  analog_sel_t   asel;
  logic [10:0]   dma_ia;
  logic [31:0]   seed = 32'h8590b88f;
  logic          scan = 1'b0;
  int            n_mismatch = 0;
  int            total_checks = 0;
  int            cycles = 0;
  int            n_done = 0;
  int            n_irq = 0;

  always #5 clk = ~clk;

  adc_control adc_control_inst (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trig_in(trig_in),
    .cpu_sleep(cpu_sleep), .sar_bit(sar_bit), .sample_hold(sample_hold),
    .sar_strobe(sar_strobe), .sar_dac(sar_dac), .asel(asel),
    .conv_done(conv_done), .irq(irq), .dma_ia(dma_ia));
  sar_model sar_model_inst (.clk(clk), .sample_hold(sample_hold),
    .vin(vin), .sar_dac(sar_dac), .sar_bit(sar_bit));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Expected buffer word for a held input under the given control one
  function automatic logic [15:0] exp_res(input logic [15:0] c1,
                                          input logic [11:0] x);
    logic [11:0] r;
    r = c1[BIT_MODE12] ? x : {2'b00, x[11:2]};
    case (c1[FORM_HI:FORM_LO])
      2'h0: return {4'h0, r};
      2'h1: return {{4{r[11]}}, r};
      2'h2: return {r, 4'h0};
      default: return {~r[11], r[10:0], 4'h0};
    endcase
  endfunction

  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cpu_sleep <= ~cpu_sleep;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // One conversion from start to stored result
  task automatic convert(input logic [15:0] c1, input logic pin);
    int k;
    seed = xs(seed);
    vin <= seed[11:0];
    wreg(OFF_CON1, c1);
    if (pin) begin
      repeat (4) @(posedge clk);
      trig_in <= 1'b1;
    end
    k = 0;
    while (conv_done !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    check({15'h0, conv_done}, 16'h0001);
    @(posedge clk);
    trig_in <= 1'b0;
    if (!scan) begin
      rreg(OFF_RES, v);
      check(v, exp_res(c1, vin));
    end
    rreg(OFF_CON1, v);
    check({15'h0, v[BIT_DONE]}, 16'h0001);
  endtask

  // Watchdog plus per-conversion monitor
  always @(negedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      stop_test();
    end
    if (irq === 1'b1) n_irq++;
    if (conv_done === 1'b1) n_done++;
    // Scan must only ever select channels flagged in scan select low
    if (scan && (conv_done === 1'b1 || sample_hold === 1'b1))
      check({15'h0000, 1'(16'h0028 >> asel.channel)}, 16'h0001);
  end

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rreg(OFF_CON1, v);
    check(v, CON1_RST);
    rreg(4'hf, v);
    check(v, ZERO_RST);
    wreg(OFF_CON1, 16'h0002);
    repeat (200) @(posedge clk);
    check(n_done[15:0], 16'h0000);
    // Configuration finishes before the module is turned on
    seed = xs(seed);
    wreg(OFF_CHS, {seed[15:13], 5'h01, seed[7:5], 5'h02});
    wreg(OFF_CON2, {seed[31:29], 13'h0004});
    wreg(OFF_CON3, 16'h0201);
    rreg(OFF_CHS, v);
    check(v, {seed[15:13], 5'h01, seed[7:5], 5'h02});
    check(asel.mux_sel, v);
    check({13'h0, asel.ref_sel}, {13'h0, seed[31:29]});
    n_irq = 0; // Bench clears its count of interrupt pulses before use
    // All four alignments in 12-bit mode
    for (int i = 0; i < 4; i++) convert({6'h21, 2'(i), 8'h02}, 1'b0);
    check(n_irq[15:0], 16'h0002);
    // Pin-started conversion in 10-bit mode, sample bit left clear
    convert(16'h8010, 1'b1);
    wreg(OFF_THR, 16'hc800);
    n_irq = 0;
    convert(16'h8402, 1'b0);
    rreg(OFF_STAT, v);
    check(v, {13'h0000, vin > 12'h800, 2'b00});
    check(n_irq[15:0], {15'h0000, vin > 12'h800});
    wreg(OFF_THR, 16'h0000);
    scan = 1'b1;
    wreg(OFF_CSSL, 16'h0028);
    wreg(OFF_CON2, 16'h0400);
    repeat (3) convert(16'h8402, 1'b0);
    stop_test();
  end
endmodule
